// file: bench/gptu_pins.sv
// Model of the external sensor, gate, event and direction pins.
`timescale 1ns/1ns
`default_nettype none
module gptu_pins (
    // Clock.
    input  wire logic i_mclk,
    // Pin levels, index 0 to 10 in this order.
    output wire logic o_core1_input_pin,
    output wire logic o_core1_direction_pin,
    output wire logic o_aux_low_input_pin,
    output wire logic o_aux_low_direction_pin,
    output wire logic o_aux_high_input_pin,
    output wire logic o_aux_high_direction_pin,
    output wire logic o_core2_input_pin,
    output wire logic o_core2_direction_pin,
    output wire logic o_aux2_input_pin,
    output wire logic o_aux2_direction_pin,
    output wire logic o_capture_trigger_pin
);
    logic [10:0] lvl = 11'h000;
    assign {o_capture_trigger_pin, o_aux2_direction_pin, o_aux2_input_pin, o_core2_direction_pin, o_core2_input_pin,
            o_aux_high_direction_pin, o_aux_high_input_pin, o_aux_low_direction_pin, o_aux_low_input_pin,
            o_core1_direction_pin, o_core1_input_pin} = lvl;
    ////////////////////////////////////////////////////////////////////////////
    task automatic set_pin(input int p, input logic v);
        @(posedge i_mclk);
        #1;
        lvl[p] = v;
    endtask
    // One-cycle pulses, gap plus one idle cycles apart.
    task automatic pulse(input int p, input int n, input int gap);
        repeat (n) begin
            set_pin(p, 1'h1);
            set_pin(p, 1'h0);
            repeat (gap) @(posedge i_mclk);
        end
    endtask
    // Holds a pin high for exactly n sampling edges.
    task automatic hold(input int p, input int n);
        set_pin(p, 1'h1);
        repeat (n - 1) @(posedge i_mclk);
        set_pin(p, 1'h0);
    endtask
    // Gray steps on A (index 0) and B (index 1).
    task automatic quad(input int n, input logic down);
        repeat (n) begin
            if ((lvl[0] ~^ lvl[1]) ^ down) set_pin(0, ~lvl[0]);
            else set_pin(1, ~lvl[1]);
            @(posedge i_mclk);
        end
    endtask
endmodule
`default_nettype wire

// file: bench/gptu_props.sv
// Concurrent checks on the ports of the timer unit top.
`timescale 1ns/1ns
`default_nettype none
module gptu_props (
    // Clock and reset.
    input wire logic        i_mclk,
    input wire logic        i_srst,
    // Configuration.
    input wire logic [2:0]  i_m1_run,
    input wire logic [5:0]  i_m1_mode,
    input wire logic [8:0]  i_m1_prescale_select,
    input wire logic [1:0]  i_aux_capture_en,
    input wire logic [1:0]  i_aux_reload_en,
    input wire logic [1:0]  i_m2_run,
    input wire logic [3:0]  i_m2_mode,
    input wire logic [5:0]  i_m2_prescale_select,
    input wire logic        i_core2_reload_en,
    input wire logic        i_capture_clear_en,
    input wire logic        i_irq_clear,
    // Observed state.
    input wire logic [15:0] o_module1_aux_timer_low,
    input wire logic [15:0] o_module1_core_timer,
    input wire logic [15:0] o_module2_aux_timer,
    input wire logic [15:0] o_module2_core_timer,
    input wire logic [15:0] o_module2_capture_reload_reg,
    input wire logic        o_core1_toggle_latch,
    input wire logic        o_core2_toggle_latch,
    input wire logic        o_core2_wrap_clock,
    input wire logic [5:0]  o_irq_flags
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////////
    a_core1_idle_hold: assert property ((!i_m1_run[1] && i_aux_reload_en == 2'h0)[*4]
        |-> $stable(o_module1_core_timer)) else $error("core one moved while stopped");
    a_aux_low_stopped: assert property ((i_aux_reload_en[0] && !i_aux_capture_en[0])[*4]
        |-> $stable(o_module1_aux_timer_low)) else $error("reload timer kept counting");
    a_core1_wrap_value: assert property ($changed(o_core1_toggle_latch) && i_aux_reload_en == 2'h0
        |-> o_module1_core_timer == 16'h0000 || o_module1_core_timer == 16'hFFFF) else $error("latch moved off wrap");
    a_core1_latch_flag: assert property ($changed(o_core1_toggle_latch) |-> o_irq_flags[1])
        else $error("core one wrap without flag");
    a_core2_latch_flag: assert property ($changed(o_core2_toggle_latch) |-> o_irq_flags[4])
        else $error("core two wrap without flag");
    a_wrap_pulse_single: assert property (o_core2_wrap_clock |=> !o_core2_wrap_clock)
        else $error("wrap clock longer than one cycle");
    a_wrap_pulse_latch: assert property ($changed(o_core2_toggle_latch)
        |-> o_core2_wrap_clock || $past(o_core2_wrap_clock)) else $error("latch toggled without wrap clock");
    a_capture_sets_flag: assert property ($changed(o_module2_capture_reload_reg) |-> o_irq_flags[5])
        else $error("capture without flag");
    a_capture_clears_aux: assert property ($changed(o_module2_capture_reload_reg) && i_capture_clear_en
        && !i_m2_run[0] |-> ##[0:3] o_module2_aux_timer == 16'h0000) else $error("aux two not cleared");
    a_flags_stay_set: assert property (!i_irq_clear && !$past(i_irq_clear)
        |=> (o_irq_flags & $past(o_irq_flags)) == $past(o_irq_flags)) else $error("flag dropped without clear");
    a_m1_tick_gap: assert property (i_m1_mode[3:2] == 2'h0 && i_m1_prescale_select[5:3] == 3'h0 && i_m1_run[1]
        && i_aux_reload_en == 2'h0 && $changed(o_module1_core_timer) |=> $stable(o_module1_core_timer)[*7])
        else $error("core one too fast");
    a_m2_tick_gap: assert property (i_m2_mode[3:2] == 2'h0 && i_m2_prescale_select[5:3] == 3'h0 && i_m2_run[1]
        && !i_core2_reload_en && $changed(o_module2_core_timer) |=> $stable(o_module2_core_timer)[*3])
        else $error("core two too fast");
endmodule
bind gptu_top gptu_props u_props (.*);
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the general purpose timer unit.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    logic i_mclk = 1'h0, i_srst = 1'h1, i_aux2_chain_latch = 1'h0, i_core2_reload_en = 1'h0;
    logic i_capture_clear_en = 1'h0, i_irq_clear = 1'h0;
    logic [2:0] i_m1_run = 3'h0, i_m1_dir_down = 3'h0, i_m1_dir_ext_en = 3'h0;
    logic [5:0] i_m1_mode = 6'h00, i_m2_prescale_select = 6'h00;
    logic [8:0] i_m1_prescale_select = 9'h000;
    logic [3:0] i_m2_mode = 4'h0;
    logic [1:0] i_aux_chain_latch = 2'h0, i_aux_capture_en = 2'h0, i_aux_reload_en = 2'h0, i_aux_reload_pin_en = 2'h0;
    logic [1:0] i_aux_reload_latch_rise = 2'h0, i_aux_reload_latch_fall = 2'h0, i_aux_trig_edge_sel = 2'h0;
    logic [1:0] i_m2_run = 2'h0, i_m2_dir_down = 2'h0, i_m2_dir_ext_en = 2'h0;
    logic [1:0] i_capture_edge_sel = 2'h0, i_capture_source_sel = 2'h0;
    wire logic i_core1_input_pin, i_core1_direction_pin, i_aux_low_input_pin, i_aux_low_direction_pin;
    wire logic i_aux_high_input_pin, i_aux_high_direction_pin, i_core2_input_pin, i_core2_direction_pin;
    wire logic i_aux2_input_pin, i_aux2_direction_pin, i_capture_trigger_pin;
    wire logic [15:0] o_module1_aux_timer_low, o_module1_core_timer, o_module1_aux_timer_high;
    wire logic [15:0] o_module2_aux_timer, o_module2_core_timer, o_module2_capture_reload_reg;
    wire logic o_core1_toggle_latch, o_core2_toggle_latch, o_core2_wrap_clock;
    wire logic [5:0] o_irq_flags;
    int fail_count = 0, samples_checked = 0, wrap_seen = 0;
    gptu_top dut (.*);
    gptu_pins pins (.i_mclk, .o_core1_input_pin(i_core1_input_pin), .o_core1_direction_pin(i_core1_direction_pin),
        .o_aux_low_input_pin(i_aux_low_input_pin), .o_aux_low_direction_pin(i_aux_low_direction_pin),
        .o_aux_high_input_pin(i_aux_high_input_pin), .o_aux_high_direction_pin(i_aux_high_direction_pin),
        .o_core2_input_pin(i_core2_input_pin), .o_core2_direction_pin(i_core2_direction_pin),
        .o_aux2_input_pin(i_aux2_input_pin), .o_aux2_direction_pin(i_aux2_direction_pin),
        .o_capture_trigger_pin(i_capture_trigger_pin));
    ////////////////////////////////////////////////////////////////////////////
    initial forever #4 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (o_core2_wrap_clock === 1'h1) wrap_seen <= wrap_seen + 1;
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    function automatic logic [15:0] core(input int w);
        return w ? o_module2_core_timer : o_module1_core_timer;
    endfunction
    // Cycles from the call until the chosen core timer changes.
    task automatic wait_chg(input int w, output int n);
        logic [15:0] prev;
        prev = core(w);
        n = 0;
        do begin tick(1); n++; end while (core(w) === prev && n < 3000);
        `CHK(n < 3000, 1'h1)
    endtask
    // Stop first so a mode change sees no stray step.
    task automatic core1_cfg(input logic [1:0] mode, input logic [2:0] sel, input logic dd, input logic de);
        i_m1_run[1] = 1'h0;
        tick(4);
        i_m1_mode[3:2] = mode;
        i_m1_prescale_select[5:3] = sel;
        i_m1_dir_down[1] = dd;
        i_m1_dir_ext_en[1] = de;
        i_m1_run[1] = 1'h1;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #(40000 * 8);
        fail_count++;
        give_verdict;
    end
    initial begin
        int n, t;
        logic [15:0] base, v;
        logic l;
        tick(12);
        i_srst = 1'h0;
        tick(2);
        `CHK({o_module1_core_timer, o_irq_flags}, 22'h000000)
        core1_cfg(2'h0, 3'h0, 1'h1, 1'h0);
        wait_chg(0, n);
        `CHK(o_module1_core_timer, 16'hFFFF)
        tick(2);
        `CHK({o_core1_toggle_latch, o_irq_flags[1]}, 2'h3)
        pins.set_pin(1, 1'h1);
        core1_cfg(2'h0, 3'h0, 1'h0, 1'h1);
        wait_chg(0, n);
        `CHK(o_module1_core_timer, 16'hFFFE)
        pins.set_pin(1, 1'h0);
        wait_chg(0, n);
        wait_chg(0, n);
        `CHK(o_module1_core_timer, 16'h0000)
        tick(2);
        `CHK(o_core1_toggle_latch, 1'h0)
        i_irq_clear = 1'h1;
        tick(3);
        i_irq_clear = 1'h0;
        tick(1);
        `CHK(o_irq_flags, 6'h00)
        core1_cfg(2'h2, 3'h0, 1'h0, 1'h0);
        base = o_module1_core_timer;
        pins.pulse(0, 5, 0);
        tick(4);
        `CHK(o_module1_core_timer, base + 16'h0005)
        core1_cfg(2'h1, 3'h0, 1'h0, 1'h0);
        base = o_module1_core_timer;
        tick(40);
        `CHK(o_module1_core_timer, base)
        pins.hold(0, 80);
        tick(4);
        `CHK(o_module1_core_timer, base + 16'h000A)
        core1_cfg(2'h3, 3'h0, 1'h0, 1'h0);
        base = o_module1_core_timer;
        pins.quad(6, 1'h0);
        pins.quad(2, 1'h1);
        tick(4);
        `CHK(o_module1_core_timer, base + 16'h0004)
        i_m1_run[1] = 1'h0;
        tick(4);
        v = o_module1_core_timer;
        i_aux_capture_en[0] = 1'h1;
        i_aux_trig_edge_sel = 2'h1;
        i_m1_run[0] = 1'h1;
        pins.pulse(2, 1, 0);
        tick(40);
        `CHK(o_module1_aux_timer_low, v)
        i_m1_mode[5:4] = 2'h2;
        i_m1_run[2] = 1'h1;
        pins.pulse(4, 3, 1);
        tick(4);
        `CHK(o_module1_aux_timer_high, 16'h0003)
        i_aux_reload_en[1] = 1'h1;
        i_aux_reload_pin_en[1] = 1'h1;
        pins.pulse(4, 1, 0);
        tick(4);
        `CHK({o_module1_core_timer, o_module1_aux_timer_high}, 32'h00030003)
        i_aux_reload_pin_en = 2'h0;
        i_aux_capture_en = 2'h0;
        i_aux_reload_en = 2'h3;
        i_aux_reload_latch_rise = 2'h1;
        i_aux_reload_latch_fall = 2'h2;
        core1_cfg(2'h0, 3'h0, 1'h1, 1'h0);
        t = 0;
        repeat (800) begin
            l = o_core1_toggle_latch;
            tick(1);
            if (o_core1_toggle_latch !== l) t++;
        end
        `CHK(t >= 3, 1'h1)
        i_m1_run = 3'h0;
        tick(4);
        i_aux_reload_en = 2'h0;
        i_m2_mode[1:0] = 2'h2;
        i_m2_run[0] = 1'h1;
        pins.pulse(8, 4, 1);
        tick(4);
        `CHK(o_module2_aux_timer, 16'h0004)
        i_m2_run[0] = 1'h0;
        i_capture_edge_sel = 2'h1;
        i_capture_clear_en = 1'h1;
        pins.pulse(10, 1, 3);
        tick(4);
        `CHK({o_module2_capture_reload_reg, o_module2_aux_timer, o_irq_flags[5]}, 33'h000080001)
        i_core2_reload_en = 1'h1;
        i_m2_dir_down[1] = 1'h1;
        i_m2_run[1] = 1'h1;
        wait_chg(1, n);
        // The wrapped value shows for one cycle before the reload lands.
        tick(1);
        `CHK(o_module2_core_timer, 16'h0004)
        tick(2);
        `CHK({o_core2_toggle_latch, o_irq_flags[4], wrap_seen == 1}, 3'h7)
        i_m2_run = 2'h0;
        i_capture_clear_en = 1'h0;
        tick(4);
        i_core2_reload_en = 1'h0;
        for (int s = 1; s < 3; s++) begin
            i_m2_run[0] = 1'h1;
            pins.pulse(8, 1, 0);
            tick(4);
            i_m2_run[0] = 1'h0;
            i_capture_source_sel = s[1:0];
            pins.set_pin(s - 1, ~pins.lvl[s - 1]);
            tick(4);
            `CHK(o_module2_capture_reload_reg, s[15:0])
            i_capture_source_sel = 2'h0;
        end
        for (int s = 0; s < 8; s++) begin
            i_m2_run[1] = 1'h0;
            core1_cfg(2'h0, s[2:0], 1'h0, 1'h0);
            i_m2_prescale_select[5:3] = s[2:0];
            i_m2_run[1] = 1'h1;
            wait_chg(0, n);
            wait_chg(0, n);
            `CHK(n, 8 << s)
            wait_chg(1, n);
            wait_chg(1, n);
            `CHK(n, 4 << s)
        end
        give_verdict;
    end
endmodule
`default_nettype wire

// file: hdl/gptu_map.vh
// Constants for the general purpose timer unit.
`ifndef GPTU_MAP_VH
`define GPTU_MAP_VH
`define GPTU_TMR_W          16
`define GPTU_MODE_W         2
`define GPTU_MODE_TIMER     2'h0
`define GPTU_MODE_GATED     2'h1
`define GPTU_MODE_COUNTER   2'h2
`define GPTU_MODE_INCR      2'h3
`define GPTU_M1_PRE_SHIFT   3
`define GPTU_M2_PRE_SHIFT   2
`define GPTU_PRE_W          10
`define GPTU_TMR_RESET      16'h0000
`define GPTU_EDGE_RISE      0
`define GPTU_EDGE_FALL      1
`endif

// file: hdl/gptu_prescaler.v
// Free running CPU clock prescaler that emits one tick per selected divisor.
`timescale 1ns/1ns
`default_nettype none
`include "gptu_map.vh"
module gptu_prescaler #(
    parameter BASE_SHIFT = `GPTU_M1_PRE_SHIFT
) (
    // Clock and reset.
    input  wire       i_mclk,
    input  wire       i_srst,
    // Divisor select.
    input  wire [2:0] i_sel,
    // Tick output.
    output reg        o_tick
);
    reg  [`GPTU_PRE_W-1:0] cnt;
    wire [`GPTU_PRE_W-1:0] limit;

    // Divisor is two to the power of base shift plus select.
    assign limit = (10'h001 << (BASE_SHIFT + i_sel)) - 10'h001;

    always @(posedge i_mclk) begin
        if (i_srst) begin
            cnt    <= 10'h000;
            o_tick <= 1'b0;
        end else if (cnt >= limit) begin
            cnt    <= 10'h000;
            o_tick <= 1'b1;
        end else begin
            cnt    <= cnt + 10'h001;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hdl/gptu_timer.v
// One 16-bit up/down timer with mode selection, load and wrap flagging.
`timescale 1ns/1ns
`default_nettype none
`include "gptu_map.vh"
module gptu_timer #(
    parameter W = `GPTU_TMR_W
) (
    // Clock and reset.
    input  wire         i_mclk,
    input  wire         i_srst,
    // Configuration.
    input  wire         i_run,
    input  wire [1:0]   i_mode,
    input  wire         i_dir_down,
    input  wire         i_dir_ext_en,
    // Count sources.
    input  wire         i_pre_tick,
    input  wire         i_ext_evt,
    input  wire         i_gate,
    input  wire         i_dir_pin,
    input  wire         i_quad_evt,
    input  wire         i_quad_down,
    // Load and clear.
    input  wire         i_load,
    input  wire [W-1:0] i_load_val,
    input  wire         i_clear,
    // State.
    output reg  [W-1:0] o_value,
    output reg          o_wrap
);
    reg  step;
    reg  down;
    wire all_ones = &o_value;
    wire all_zero = ~|o_value;

    always @* begin
        down = i_dir_down ^ (i_dir_ext_en & i_dir_pin);
        case (i_mode)
            `GPTU_MODE_TIMER:   step = i_pre_tick;
            `GPTU_MODE_GATED:   step = i_pre_tick & i_gate;
            `GPTU_MODE_COUNTER: step = i_ext_evt;
            `GPTU_MODE_INCR: begin
                step = i_quad_evt;
                down = i_quad_down;
            end
            default:            step = 1'b0;
        endcase
        step = step & i_run;
    end

    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_value <= `GPTU_TMR_RESET;
            o_wrap  <= 1'b0;
        end else begin
            o_wrap <= step & (down ? all_zero : all_ones);
            if (i_load)
                o_value <= i_load_val;
            else if (i_clear)
                o_value <= {W{1'b0}};
            else if (step)
                o_value <= down ? o_value - 1'b1 : o_value + 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: hdl/gptu_top.v
// Top of the general purpose timer unit with both timer modules.
`timescale 1ns/1ns
`default_nettype none
`include "gptu_map.vh"
module gptu_top (
    // Clock and reset.
    input  wire        i_mclk,
    input  wire        i_srst,
    // First module pins.
    input  wire        i_core1_input_pin,
    input  wire        i_core1_direction_pin,
    input  wire        i_aux_low_input_pin,
    input  wire        i_aux_low_direction_pin,
    input  wire        i_aux_high_input_pin,
    input  wire        i_aux_high_direction_pin,
    // Second module pins.
    input  wire        i_core2_input_pin,
    input  wire        i_core2_direction_pin,
    input  wire        i_aux2_input_pin,
    input  wire        i_aux2_direction_pin,
    input  wire        i_capture_trigger_pin,
    // First module configuration, three timers packed low to high as aux low, core, aux high.
    input  wire [2:0]  i_m1_run,
    input  wire [5:0]  i_m1_mode,
    input  wire [8:0]  i_m1_prescale_select,
    input  wire [2:0]  i_m1_dir_down,
    input  wire [2:0]  i_m1_dir_ext_en,
    input  wire [1:0]  i_aux_chain_latch,
    input  wire [1:0]  i_aux_capture_en,
    input  wire [1:0]  i_aux_reload_en,
    input  wire [1:0]  i_aux_reload_pin_en,
    input  wire [1:0]  i_aux_reload_latch_rise,
    input  wire [1:0]  i_aux_reload_latch_fall,
    input  wire [1:0]  i_aux_trig_edge_sel,
    // Second module configuration, packed as aux, core.
    input  wire [1:0]  i_m2_run,
    input  wire [3:0]  i_m2_mode,
    input  wire [5:0]  i_m2_prescale_select,
    input  wire [1:0]  i_m2_dir_down,
    input  wire [1:0]  i_m2_dir_ext_en,
    input  wire        i_aux2_chain_latch,
    input  wire        i_core2_reload_en,
    input  wire [1:0]  i_capture_edge_sel,
    input  wire [1:0]  i_capture_source_sel,
    input  wire        i_capture_clear_en,
    input  wire        i_irq_clear,
    // Timer values.
    output reg  [15:0] o_module1_aux_timer_low,
    output reg  [15:0] o_module1_core_timer,
    output reg  [15:0] o_module1_aux_timer_high,
    output reg  [15:0] o_module2_aux_timer,
    output reg  [15:0] o_module2_core_timer,
    output reg  [15:0] o_module2_capture_reload_reg,
    // Toggle latches and outputs.
    output reg         o_core1_toggle_latch,
    output reg         o_core2_toggle_latch,
    output reg         o_core2_wrap_clock,
    // Request flags: aux low, core1, aux high, aux2, core2, capture.
    output reg  [5:0]  o_irq_flags
);
    ////////////////////////////////////////////////////////////////////////////
    // Edge detection helpers.

    function edge_hit;
        input       now;
        input       prev;
        input [1:0] sel;
        begin
            edge_hit = (sel[`GPTU_EDGE_RISE] & now & ~prev) |
                       (sel[`GPTU_EDGE_FALL] & ~now & prev);
        end
    endfunction

    reg  [10:0] pin_prev;
    wire [10:0] pin_now = {i_capture_trigger_pin, i_aux2_direction_pin, i_aux2_input_pin,
                           i_core2_direction_pin, i_core2_input_pin,
                           i_aux_high_direction_pin, i_aux_high_input_pin,
                           i_aux_low_direction_pin, i_aux_low_input_pin,
                           i_core1_direction_pin, i_core1_input_pin};
    reg         t3l_prev;
    reg         t6l_prev;

    always @(posedge i_mclk) begin
        if (i_srst) begin
            pin_prev <= 11'h000;
            t3l_prev <= 1'b0;
            t6l_prev <= 1'b0;
        end else begin
            pin_prev <= pin_now;
            t3l_prev <= o_core1_toggle_latch;
            t6l_prev <= o_core2_toggle_latch;
        end
    end

    // Quadrature decode for a timer whose A is its input pin and B its direction pin.
    function [1:0] quad;
        input a;
        input b;
        input pa;
        input pb;
        begin
            quad[0] = (a ^ pa) | (b ^ pb);
            quad[1] = (a ^ pa) ? (a == b) : (a != b);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // First module.

    wire [2:0]  m1_tick;
    wire [47:0] m1_val;
    wire [2:0]  m1_wrap;
    wire [1:0]  m1_q0 = quad(i_aux_low_input_pin, i_aux_low_direction_pin, pin_prev[2], pin_prev[3]);
    wire [1:0]  m1_q1 = quad(i_core1_input_pin, i_core1_direction_pin, pin_prev[0], pin_prev[1]);
    wire [1:0]  m1_q2 = quad(i_aux_high_input_pin, i_aux_high_direction_pin, pin_prev[4], pin_prev[5]);
    wire [2:0]  q_evt  = {m1_q2[0], m1_q1[0], m1_q0[0]};
    wire [2:0]  q_down = {m1_q2[1], m1_q1[1], m1_q0[1]};
    wire [2:0]  m1_in  = {i_aux_high_input_pin, i_core1_input_pin, i_aux_low_input_pin};
    wire [2:0]  m1_dp  = {i_aux_high_direction_pin, i_core1_direction_pin, i_aux_low_direction_pin};
    wire [2:0]  m1_inp = {pin_prev[4], pin_prev[0], pin_prev[2]};
    wire        t3l_edge = o_core1_toggle_latch ^ t3l_prev;
    wire [1:0]  aux_pin_trig;
    wire [1:0]  aux_latch_trig;
    wire [1:0]  aux_capture;
    wire [1:0]  aux_reload;
    wire [2:0]  m1_ext;
    wire [2:0]  m1_run;
    wire        core1_load;
    wire [15:0] core1_load_val;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_aux
            localparam integer IDX = 2 * g;
            assign aux_pin_trig[g] = edge_hit(m1_in[IDX], m1_inp[IDX], i_aux_trig_edge_sel);
            assign aux_latch_trig[g] = (i_aux_reload_latch_rise[g] & o_core1_toggle_latch & ~t3l_prev) |
                                       (i_aux_reload_latch_fall[g] & ~o_core1_toggle_latch & t3l_prev);
            assign aux_capture[g] = i_aux_capture_en[g] & aux_pin_trig[g];
            assign aux_reload[g]  = i_aux_reload_en[g] &
                                    ((i_aux_reload_pin_en[g] & aux_pin_trig[g]) | aux_latch_trig[g]);
        end
        for (g = 0; g < 3; g = g + 1) begin : g_m1
            // Auxiliary timers may count on core latch edges instead of their pin.
            if (g == 1) begin : g_core
                assign m1_ext[g] = edge_hit(m1_in[g], m1_inp[g], 2'h1);
                assign m1_run[g] = i_m1_run[g];
            end else begin : g_side
                assign m1_ext[g] = i_aux_chain_latch[g/2] ? t3l_edge
                                                          : edge_hit(m1_in[g], m1_inp[g], 2'h1);
                assign m1_run[g] = i_m1_run[g] & ~i_aux_capture_en[g/2] & ~i_aux_reload_en[g/2];
            end
            gptu_prescaler #(
                .BASE_SHIFT(`GPTU_M1_PRE_SHIFT)
            ) u_pre (
                .i_mclk (i_mclk),
                .i_srst (i_srst),
                .i_sel  (i_m1_prescale_select[3*g +: 3]),
                .o_tick (m1_tick[g])
            );
            gptu_timer u_tmr (
                .i_mclk       (i_mclk),
                .i_srst       (i_srst),
                .i_run        (m1_run[g]),
                .i_mode       (i_m1_mode[2*g +: 2]),
                .i_dir_down   (i_m1_dir_down[g]),
                .i_dir_ext_en (i_m1_dir_ext_en[g]),
                .i_pre_tick   (m1_tick[g]),
                .i_ext_evt    (m1_ext[g]),
                .i_gate       (m1_in[g]),
                .i_dir_pin    (m1_dp[g]),
                .i_quad_evt   (q_evt[g]),
                .i_quad_down  (q_down[g]),
                .i_load       ((g == 1) ? core1_load : aux_capture[g/2]),
                .i_load_val   ((g == 1) ? core1_load_val : m1_val[31:16]),
                .i_clear      (1'b0),
                .o_value      (m1_val[16*g +: 16]),
                .o_wrap       (m1_wrap[g])
            );
        end
    endgenerate

    // Low auxiliary timer takes priority if both reload at once.
    assign core1_load     = |aux_reload;
    assign core1_load_val = aux_reload[0] ? m1_val[15:0] : m1_val[47:32];

    ////////////////////////////////////////////////////////////////////////////
    // Second module.

    wire [1:0]  m2_tick;
    wire [31:0] m2_val;
    wire [1:0]  m2_wrap;
    wire [1:0]  m2_in  = {i_core2_input_pin, i_aux2_input_pin};
    wire [1:0]  m2_inp = {pin_prev[6], pin_prev[8]};
    wire [1:0]  m2_dp  = {i_core2_direction_pin, i_aux2_direction_pin};
    wire [1:0]  m2_ext;
    wire        t6l_edge = o_core2_toggle_latch ^ t6l_prev;
    wire        cap_src_pin = edge_hit(i_capture_trigger_pin, pin_prev[10], i_capture_edge_sel);
    wire        cap_src_t3  = (i_capture_source_sel[0] & (i_core1_input_pin ^ pin_prev[0])) |
                              (i_capture_source_sel[1] & (i_core1_direction_pin ^ pin_prev[1]));
    wire        capture2   = (|i_capture_source_sel) ? cap_src_t3 : cap_src_pin;
    wire        core2_load = i_core2_reload_en & m2_wrap[1];

    assign m2_ext[0] = i_aux2_chain_latch ? t6l_edge : edge_hit(m2_in[0], m2_inp[0], 2'h1);
    assign m2_ext[1] = edge_hit(m2_in[1], m2_inp[1], 2'h1);

    generate
        for (g = 0; g < 2; g = g + 1) begin : g_m2
            gptu_prescaler #(
                .BASE_SHIFT(`GPTU_M2_PRE_SHIFT)
            ) u_pre (
                .i_mclk (i_mclk),
                .i_srst (i_srst),
                .i_sel  (i_m2_prescale_select[3*g +: 3]),
                .o_tick (m2_tick[g])
            );
            gptu_timer u_tmr (
                .i_mclk       (i_mclk),
                .i_srst       (i_srst),
                .i_run        (i_m2_run[g]),
                .i_mode       ({i_m2_mode[2*g+1], i_m2_mode[2*g] & ~i_m2_mode[2*g+1]}),
                .i_dir_down   (i_m2_dir_down[g]),
                .i_dir_ext_en (i_m2_dir_ext_en[g]),
                .i_pre_tick   (m2_tick[g]),
                .i_ext_evt    (m2_ext[g]),
                .i_gate       (m2_in[g]),
                .i_dir_pin    (m2_dp[g]),
                .i_quad_evt   (1'b0),
                .i_quad_down  (1'b0),
                .i_load       ((g == 1) ? core2_load : 1'b0),
                .i_load_val   (o_module2_capture_reload_reg),
                .i_clear      ((g == 0) ? (capture2 & i_capture_clear_en) : 1'b0),
                .o_value      (m2_val[16*g +: 16]),
                .o_wrap       (m2_wrap[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Output registers, toggle latches and request flags.

    wire [5:0] irq_set = {capture2, m2_wrap[1], m2_wrap[0], m1_wrap[2], m1_wrap[1], m1_wrap[0]};

    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_module1_aux_timer_low      <= 16'h0000;
            o_module1_core_timer         <= 16'h0000;
            o_module1_aux_timer_high     <= 16'h0000;
            o_module2_aux_timer          <= 16'h0000;
            o_module2_core_timer         <= 16'h0000;
            o_module2_capture_reload_reg <= 16'h0000;
            o_core1_toggle_latch         <= 1'b0;
            o_core2_toggle_latch         <= 1'b0;
            o_core2_wrap_clock           <= 1'b0;
            o_irq_flags                  <= 6'h00;
        end else begin
            o_module1_aux_timer_low  <= m1_val[15:0];
            o_module1_core_timer     <= m1_val[31:16];
            o_module1_aux_timer_high <= m1_val[47:32];
            o_module2_aux_timer      <= m2_val[15:0];
            o_module2_core_timer     <= m2_val[31:16];
            if (capture2)
                o_module2_capture_reload_reg <= m2_val[15:0];
            if (m1_wrap[1])
                o_core1_toggle_latch <= ~o_core1_toggle_latch;
            if (m2_wrap[1])
                o_core2_toggle_latch <= ~o_core2_toggle_latch;
            o_core2_wrap_clock <= m2_wrap[1];
            // A set in the same cycle as the clear wins.
            o_irq_flags <= (o_irq_flags & ~{6{i_irq_clear}}) | irq_set;
        end
    end
endmodule
`default_nettype wire
